//--- common/adfc_pkg.sv
// shared constants and helpers for the conversion result filter and comparator channel enable block
package adfc_pkg;
    localparam int unsigned NUM_FILTERS      = 4;
    localparam int unsigned NUM_CMP          = 4;
    localparam int unsigned SAMPLE_W         = 12;
    localparam int unsigned ACC_W            = 20;
    localparam int unsigned RESULT_W         = 16;
    localparam int unsigned CHAN_W           = 5;
    localparam int unsigned NUM_CHANNELS     = 21;
    localparam int unsigned IDX_W            = 6;
    // register byte offsets, instance i sits at base + 4*i
    localparam logic [7:0]  OFF_FILTER_CTRL  = 8'h00;
    localparam logic [7:0]  OFF_FILTER_DATA  = 8'h10;
    localparam logic [7:0]  OFF_CMP_EN_LOW   = 8'h20;
    localparam logic [7:0]  OFF_CMP_EN_HIGH  = 8'h30;
    localparam logic [7:0]  OFF_IRQ_STATUS   = 8'h40;
    localparam logic [7:0]  OFF_IRQ_MASK     = 8'h44;
    // filter control field positions
    localparam int unsigned BIT_FILTER_ON    = 15;
    localparam int unsigned POS_MODE         = 13;
    localparam int unsigned POS_RATIO        = 10;
    localparam int unsigned BIT_IRQ_ENABLE   = 9;
    localparam int unsigned BIT_READY        = 8;
    localparam int unsigned POS_INPUT_SEL    = 0;
    localparam logic [15:0] CTRL_WRITE_MASK  = 16'hfe1f;
    localparam logic [15:0] CTRL_RESET       = 16'h0000;
    localparam logic [15:0] CMP_EN_RESET     = 16'h0000;
    localparam logic [4:0]  CMP_EN_HIGH_MASK = 5'h1f;
    localparam logic [3:0]  IRQ_MASK_RESET   = 4'h0;
    localparam logic [1:0]  MODE_OVERSAMPLE  = 2'h0;
    localparam logic [1:0]  MODE_AVERAGE     = 2'h3;

    // log2 of the sample count for a ratio code
    function automatic logic [3:0] ratio_log2(input logic avg, input logic [2:0] code);
        logic [3:0] n;
        n = {1'b0, code} + 4'h1;
        if (!avg) begin
            n = code[2] ? ({1'b0, code[1:0], 1'b0} + 4'h1) : ({1'b0, code[1:0], 1'b0} + 4'h2);
        end
        return n;
    endfunction

    // right shift that turns the accumulated sum into the published result
    function automatic logic [3:0] result_shift(input logic avg, input logic [3:0] l2);
        logic [3:0] s;
        s = l2;
        if (!avg) begin
            s = l2 - ((l2 + 4'h1) >> 1);
        end
        return s;
    endfunction
endpackage

//--- rtl/adfc_filter_unit.sv
// one oversampling / averaging filter instance
`timescale 1ns/100ps
`default_nettype none
module adfc_filter_unit
    import adfc_pkg::*;
#(
    parameter int unsigned DATA_W = adfc_pkg::SAMPLE_W
) (
    input  wire logic                          hclk,
    input  wire logic                          hresetn,
    input  wire logic                          filter_on,
    input  wire logic [1:0]                    mode,
    input  wire logic [2:0]                    sample_ratio_select,
    input  wire logic [adfc_pkg::CHAN_W-1:0]   filter_input_select,
    input  wire logic                          conv_valid,
    input  wire logic [adfc_pkg::CHAN_W-1:0]   conv_channel,
    input  wire logic [DATA_W-1:0]             conv_data,
    output logic [adfc_pkg::RESULT_W-1:0]      result_r,
    output logic                               done_r
);
    logic [ACC_W-1:0] acc_r;
    logic [8:0]       cnt_r;
    wire logic        avg       = (mode == MODE_AVERAGE);
    wire logic        mode_ok   = avg || (mode == MODE_OVERSAMPLE);
    wire logic        take      = filter_on && mode_ok && conv_valid && (conv_channel == filter_input_select);
    wire logic [3:0]  l2        = ratio_log2(avg, sample_ratio_select);
    wire logic [8:0]  last      = 9'((10'h001 << l2) - 10'h001);
    wire logic [ACC_W-1:0] acc_nxt = acc_r + ACC_W'(conv_data);
    wire logic [ACC_W-1:0] scaled  = acc_nxt >> result_shift(avg, l2);

    // reserved mode codes leave the filter idle rather than guessing a behaviour
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_r    <= '0;
            cnt_r    <= '0;
            result_r <= '0;
            done_r   <= 1'b0;
        end else begin
            done_r <= 1'b0;
            if (!filter_on) begin
                acc_r <= '0;
                cnt_r <= '0;
            end else if (take && cnt_r >= last) begin
                result_r <= scaled[RESULT_W-1:0];
                acc_r    <= '0;
                cnt_r    <= '0;
                done_r   <= 1'b1;
            end else if (take) begin
                acc_r <= acc_nxt;
                cnt_r <= cnt_r + 9'h001;
            end
        end
    end
endmodule
`default_nettype wire

//--- rtl/adfc_irq.sv
// sticky interrupt status with mask, cleared by a status read
`timescale 1ns/100ps
`default_nettype none
module adfc_irq #(
    parameter int unsigned N = 4
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [N-1:0] event_in,
    input  wire logic         status_read,
    input  wire logic         mask_write,
    input  wire logic [N-1:0] mask_wdata,
    output logic [N-1:0]      status_r,
    output logic [N-1:0]      mask_r,
    output logic              irq
);
    // a new event in the clearing cycle survives the read
    wire logic [N-1:0] status_nxt = (status_read ? '0 : status_r) | event_in;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_r <= '0;
            mask_r   <= N'(adfc_pkg::IRQ_MASK_RESET);
        end else begin
            status_r <= status_nxt;
            if (mask_write) begin
                mask_r <= mask_wdata;
            end
        end
    end

    assign irq = |(status_r & mask_r);
endmodule
`default_nettype wire

//--- rtl/adfc_top.sv
// conversion result filters and comparator channel enables behind an AHB-Lite slave
`timescale 1ns/100ps
`default_nettype none
module adfc_top
    import adfc_pkg::*;
#(
    parameter int unsigned NF = adfc_pkg::NUM_FILTERS,
    parameter int unsigned NC = adfc_pkg::NUM_CMP
) (
    input  wire logic                         hclk,
    input  wire logic                         hresetn,
    input  wire logic                         hsel,
    input  wire logic [31:0]                  haddr,
    input  wire logic [1:0]                   htrans,
    input  wire logic                         hwrite,
    input  wire logic [2:0]                   hsize,
    input  wire logic                         hready,
    input  wire logic [31:0]                  hwdata,
    output logic [31:0]                       hrdata,
    output logic                              hreadyout,
    output logic                              hresp,
    input  wire logic                         conv_valid,
    input  wire logic [adfc_pkg::CHAN_W-1:0]  conv_channel,
    input  wire logic [adfc_pkg::SAMPLE_W-1:0] conv_data,
    output logic [NC-1:0]                     cmp_feed_valid_r,
    output logic [adfc_pkg::CHAN_W-1:0]       cmp_feed_channel_r,
    output logic [adfc_pkg::SAMPLE_W-1:0]     cmp_feed_data_r,
    output logic [NF-1:0]                     filter_ready,
    output logic                              irq
);
    import adfc_pkg::*;

    // bus address/data phase tracking
    logic              wr_pend_r;
    logic              rd_pend_r;
    logic [IDX_W-1:0]  idx_r;

    // register storage
    logic [15:0]       ctrl_r [NF];
    logic [15:0]       cmp_en_low_r [NC];
    logic [4:0]        cmp_en_high_r [NC];
    logic [NF-1:0]     ready_r;

    // filter outputs
    logic [RESULT_W-1:0] result_w [NF];
    logic [NF-1:0]       done_w;

    // interrupt block outputs
    logic [NF-1:0]     irq_status_w;
    logic [NF-1:0]     irq_mask_w;

    // word index of a byte offset
    function automatic logic [IDX_W-1:0] word_idx(input logic [7:0] off);
        return off[7:2];
    endfunction

    wire logic             addr_phase = hsel && htrans[1] && hready;
    wire logic [IDX_W-1:0] addr_idx   = haddr[IDX_W+1:2];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            idx_r     <= '0;
        end else begin
            wr_pend_r <= addr_phase && hwrite;
            rd_pend_r <= addr_phase && !hwrite;
            if (addr_phase) begin
                idx_r <= addr_idx;
            end
        end
    end

    // zero wait states, every access answered OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // decode of the data-phase index into register groups
    wire logic [IDX_W-1:0] base_ctrl  = word_idx(OFF_FILTER_CTRL);
    wire logic [IDX_W-1:0] base_data  = word_idx(OFF_FILTER_DATA);
    wire logic [IDX_W-1:0] base_enl   = word_idx(OFF_CMP_EN_LOW);
    wire logic [IDX_W-1:0] base_enh   = word_idx(OFF_CMP_EN_HIGH);
    wire logic             hit_ctrl   = (idx_r >= base_ctrl) && (idx_r < base_ctrl + IDX_W'(NF));
    wire logic             hit_data   = (idx_r >= base_data) && (idx_r < base_data + IDX_W'(NF));
    wire logic             hit_enl    = (idx_r >= base_enl)  && (idx_r < base_enl + IDX_W'(NC));
    wire logic             hit_enh    = (idx_r >= base_enh)  && (idx_r < base_enh + IDX_W'(NC));
    wire logic             hit_status = (idx_r == word_idx(OFF_IRQ_STATUS));
    wire logic             hit_mask   = (idx_r == word_idx(OFF_IRQ_MASK));
    wire logic [1:0]       sub        = idx_r[1:0];

    wire logic             wr_ctrl    = wr_pend_r && hit_ctrl;
    wire logic             wr_enl     = wr_pend_r && hit_enl;
    wire logic             wr_enh     = wr_pend_r && hit_enh;
    wire logic             wr_mask    = wr_pend_r && hit_mask;
    wire logic             rd_data    = rd_pend_r && hit_data;
    wire logic             rd_status  = rd_pend_r && hit_status;

    // control registers: ready bit is hardware owned, bits 7..5 never stored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NF; i++) begin
                ctrl_r[i] <= CTRL_RESET;
            end
        end else if (wr_ctrl) begin
            ctrl_r[sub] <= hwdata[15:0] & CTRL_WRITE_MASK;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NC; i++) begin
                cmp_en_low_r[i]  <= CMP_EN_RESET;
                cmp_en_high_r[i] <= CMP_EN_RESET[4:0];
            end
        end else begin
            if (wr_enl) begin
                cmp_en_low_r[sub] <= hwdata[15:0];
            end
            if (wr_enh) begin
                cmp_en_high_r[sub] <= hwdata[4:0] & CMP_EN_HIGH_MASK;
            end
        end
    end

    // field views of each filter control register
    logic [NF-1:0] f_on;
    logic [NF-1:0] f_irq_en;
    logic [1:0]    f_mode   [NF];
    logic [2:0]    f_ratio  [NF];
    logic [4:0]    f_insel  [NF];

    always_comb begin
        for (int i = 0; i < NF; i++) begin
            f_on[i]     = ctrl_r[i][BIT_FILTER_ON];
            f_irq_en[i] = ctrl_r[i][BIT_IRQ_ENABLE];
            f_mode[i]   = ctrl_r[i][POS_MODE +: 2];
            f_ratio[i]  = ctrl_r[i][POS_RATIO +: 3];
            f_insel[i]  = ctrl_r[i][POS_INPUT_SEL +: CHAN_W];
        end
    end

    // input codes above the band gap are not range checked, so a result carrying the same channel code still feeds the filter
    for (genvar g = 0; g < NF; g++) begin : g_filter
        adfc_filter_unit #(
            .DATA_W (SAMPLE_W)
        ) u_filter (
            .hclk                (hclk),
            .hresetn             (hresetn),
            .filter_on           (f_on[g]),
            .mode                (f_mode[g]),
            .sample_ratio_select (f_ratio[g]),
            .filter_input_select (f_insel[g]),
            .conv_valid          (conv_valid),
            .conv_channel        (conv_channel),
            .conv_data           (conv_data),
            .result_r            (result_w[g]),
            .done_r              (done_w[g])
        );
    end

    // ready: disable forces clear, a new result beats a read in the same cycle
    logic [NF-1:0] rd_data_hit;
    always_comb begin
        rd_data_hit = '0;
        if (rd_data) begin
            rd_data_hit[sub] = 1'b1;
        end
    end

    wire logic [NF-1:0] ready_nxt = f_on & (done_w | (ready_r & ~rd_data_hit));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready_r <= '0;
        end else begin
            ready_r <= ready_nxt;
        end
    end

    assign filter_ready = ready_r;

    // only filters with their enable bit set feed the common interrupt
    adfc_irq #(
        .N (NF)
    ) u_irq (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .event_in    (done_w & f_irq_en),
        .status_read (rd_status),
        .mask_write  (wr_mask),
        .mask_wdata  (hwdata[NF-1:0]),
        .status_r    (irq_status_w),
        .mask_r      (irq_mask_w),
        .irq         (irq)
    );

    // comparator feed: a result passes to comparator c only if its channel is enabled there
    logic [NC-1:0] ch_use;
    always_comb begin
        for (int c = 0; c < NC; c++) begin
            ch_use[c] = 1'b0;
            if (conv_channel < 5'd16) begin
                ch_use[c] = cmp_en_low_r[c][conv_channel[3:0]];
            end else if (conv_channel < 5'(NUM_CHANNELS)) begin
                ch_use[c] = cmp_en_high_r[c][3'(conv_channel - 5'd16)];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmp_feed_valid_r   <= '0;
            cmp_feed_channel_r <= '0;
            cmp_feed_data_r    <= '0;
        end else begin
            cmp_feed_valid_r <= {NC{conv_valid}} & ch_use;
            if (conv_valid) begin
                cmp_feed_channel_r <= conv_channel;
                cmp_feed_data_r    <= conv_data;
            end
        end
    end

    // read mux on the data-phase index; unmapped words read zero
    logic [15:0] rd_word;
    always_comb begin
        rd_word = 16'h0000;
        if (hit_ctrl) begin
            rd_word = ctrl_r[sub];
            rd_word[BIT_READY] = ready_r[sub];
        end else if (hit_data) begin
            rd_word = result_w[sub];
        end else if (hit_enl) begin
            rd_word = cmp_en_low_r[sub];
        end else if (hit_enh) begin
            rd_word = {11'h000, cmp_en_high_r[sub]};
        end else if (hit_status) begin
            rd_word = {{(16-NF){1'b0}}, irq_status_w};
        end else if (hit_mask) begin
            rd_word = {{(16-NF){1'b0}}, irq_mask_w};
        end
    end

    // only driven in a read data phase so idle cycles keep the bus quiet
    assign hrdata = rd_pend_r ? {16'h0000, rd_word} : 32'h0000_0000;
endmodule
`default_nettype wire

//--- test/adfc_top_chk.sv
// port-level assertions for the result filter block
`timescale 1ns/100ps
`default_nettype none
module adfc_top_chk
    import adfc_pkg::*;
#(
    parameter int unsigned NF = 4,
    parameter int unsigned NC = 4
) (
    input wire logic                           hclk,
    input wire logic                           hresetn,
    input wire logic                           hsel,
    input wire logic [31:0]                    haddr,
    input wire logic [1:0]                     htrans,
    input wire logic                           hwrite,
    input wire logic [2:0]                     hsize,
    input wire logic                           hready,
    input wire logic [31:0]                    hwdata,
    input wire logic [31:0]                    hrdata,
    input wire logic                           hreadyout,
    input wire logic                           hresp,
    input wire logic                           conv_valid,
    input wire logic [adfc_pkg::CHAN_W-1:0]    conv_channel,
    input wire logic [adfc_pkg::SAMPLE_W-1:0]  conv_data,
    input wire logic [NC-1:0]                  cmp_feed_valid_r,
    input wire logic [adfc_pkg::CHAN_W-1:0]    cmp_feed_channel_r,
    input wire logic [adfc_pkg::SAMPLE_W-1:0]  cmp_feed_data_r,
    input wire logic [NF-1:0]                  filter_ready,
    input wire logic                           irq
);
    logic       rd_ph_r;
    logic [7:0] rd_a_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_ph_r <= 1'b0;
            rd_a_r  <= 8'h00;
        end else begin
            rd_ph_r <= hsel && htrans[1] && hready && !hwrite;
            rd_a_r  <= haddr[7:0];
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_taken;
        conv_valid ##1 1'b1;
    endsequence
    chk_resp_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1) else $error("bus answer not okay");
    chk_rdata_idle: assert property (!rd_ph_r |-> hrdata == 32'h0) else $error("read data outside data phase");
    chk_ctrl_gap: assert property (rd_ph_r && rd_a_r[7:4] == 4'h0 |-> hrdata[7:5] == 3'h0)
        else $error("control gap bits not zero");
    chk_high_zero: assert property (rd_ph_r && rd_a_r[7:4] == 4'h3 |-> hrdata[31:5] == '0)
        else $error("high enable upper bits not zero");
    chk_feed_cause: assert property (cmp_feed_valid_r != '0 |-> $past(conv_valid))
        else $error("comparator feed without a result");
    chk_feed_copy: assert property (s_taken |-> cmp_feed_data_r == $past(conv_data)
        && cmp_feed_channel_r == $past(conv_channel)) else $error("comparator feed data wrong");
    chk_feed_none: assert property (conv_valid && conv_channel > 5'd20 |=> cmp_feed_valid_r == '0)
        else $error("reserved channel fed to comparator");
    chk_ready_cause: assert property ((filter_ready & ~$past(filter_ready)) != '0
        |-> $past(conv_valid) || $past(conv_valid, 2) || $past(conv_valid, 3)) else $error("ready without sample");
endmodule
bind adfc_top adfc_top_chk #(.NF(NF), .NC(NC)) u_adfc_top_chk (.*);
`default_nettype wire

//--- test/adfc_conv_model.sv
// stand-in for the converter core that hands over conversion results
`timescale 1ns/100ps
`default_nettype none
module adfc_conv_model (
    output logic        conv_valid,
    output logic [4:0]  conv_channel,
    output logic [11:0] conv_data,
    input  wire logic   hclk
);
    initial begin
        conv_valid   = 1'b0;
        conv_channel = 5'h1f;
        conv_data    = 12'h000;
    end
    // idle lines carry the inverse so a stale value never looks fresh
    task automatic send(input logic [4:0] ch, input logic [11:0] d);
        conv_valid   <= 1'b1;
        conv_channel <= ch;
        conv_data    <= d;
        @(posedge hclk);
        conv_valid   <= 1'b0;
        conv_channel <= ~ch;
        conv_data    <= ~d;
    endtask
endmodule
`default_nettype wire

//--- test/adc_result_filter_and_compare_enable_test.sv
// register, comparator feed and filter tests for the result filter block
`timescale 1ns/100ps
`default_nettype none
module adc_result_filter_and_compare_enable_test;
    import adfc_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, cv;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [3:0]  cfv, fr, ev;
    logic [4:0]  cch, fcs, fch;
    logic [11:0] cd, fcd;
    logic [15:0] en_lo [4];
    logic [4:0]  en_hi [4];
    int          n_errors = 0, n_compared = 0, cyc = 0, nsmp;
    int          os_n [8] = '{4, 16, 64, 256, 2, 8, 32, 128};
    int          os_f [8] = '{1, 2, 3, 4, 1, 2, 3, 4};
    adfc_top u_adfc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .conv_valid(cv), .conv_channel(cch), .conv_data(cd),
        .cmp_feed_valid_r(cfv), .cmp_feed_channel_r(fcs), .cmp_feed_data_r(fcd), .filter_ready(fr), .irq(irq));
    adfc_conv_model u_adfc_conv_model (.conv_valid(cv), .conv_channel(cch), .conv_data(cd), .hclk(hclk));
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors = n_errors + 1;
            stop_test();
        end
    end
    function automatic logic [31:0] ctl(logic on, logic [1:0] md, logic [2:0] r, logic ie, logic [4:0] ch);
        return {16'h0, on, md, r, ie, 4'h0, ch};
    endfunction
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        cmp(q, exp);
    endtask
    // waits for a registered flag to land, off the edge; callers step back onto an edge before driving
    task automatic pause(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask
    task automatic stop_test();
        $display("errors=%0d compared=%0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = '0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rdc(OFF_FILTER_CTRL + 8'(4 * i), 32'h0);
            rdc(OFF_CMP_EN_LOW + 8'(4 * i), 32'h0);
            rdc(OFF_CMP_EN_HIGH + 8'(4 * i), 32'h0);
        end
        rdc(OFF_IRQ_STATUS, 32'h0);
        rdc(OFF_IRQ_MASK, 32'h0);
        xfer(8'h80, 1'b1, 32'hffffffff);
        rdc(8'h80, 32'h0);
        xfer(OFF_CMP_EN_HIGH, 1'b1, 32'hffffffff);
        rdc(OFF_CMP_EN_HIGH, 32'h1f);
        xfer(OFF_FILTER_CTRL + 8'h0c, 1'b1, 32'h0000ffff);
        rdc(OFF_FILTER_CTRL + 8'h0c, 32'hfe1f);
        xfer(OFF_FILTER_CTRL + 8'h0c, 1'b1, 32'h0);
        $display("test registers done");
        for (int c = 0; c < 4; c++) begin
            en_lo[c] = 16'h1111 << c;
            en_hi[c] = (c == 0) ? 5'h11 : 5'(1 << c);
            xfer(OFF_CMP_EN_LOW + 8'(4 * c), 1'b1, {16'h0, en_lo[c]});
            xfer(OFF_CMP_EN_HIGH + 8'(4 * c), 1'b1, {27'h0, en_hi[c]});
        end
        for (int ch = 0; ch < 22; ch++) begin
            for (int c = 0; c < 4; c++) ev[c] = 1'({en_hi[c], en_lo[c]} >> ch);
            u_adfc_conv_model.send(5'(ch), 12'(ch * 97));
            #1;
            cmp({28'h0, cfv}, {28'h0, ev});
            cmp({15'h0, fcs, fcd}, {15'h0, 5'(ch), 12'(ch * 97)});
            @(posedge hclk);
        end
        $display("test comparator feed done");
        xfer(OFF_IRQ_MASK, 1'b1, 32'hf);
        for (int m = 0; m < 2; m++) begin
            for (int k = 0; k < 8; k++) begin
                nsmp = m ? (2 << k) : os_n[k];
                xfer(OFF_FILTER_CTRL, 1'b1, ctl(1'b1, m ? 2'b11 : 2'b00, 3'(k), 1'b1, 5'd3));
                for (int s = 0; s < nsmp; s++) begin
                    if (s == nsmp - 1) begin
                        u_adfc_conv_model.send(5'd4, 12'h000);
                        pause(1);
                        cmp({28'h0, fr}, 32'h0);
                        @(posedge hclk);
                    end
                    u_adfc_conv_model.send(5'd3, 12'hfff);
                    @(posedge hclk);
                end
                pause(2);
                cmp({28'h0, fr}, 32'h1);
                cmp({31'h0, irq}, 32'h1);
                @(posedge hclk);
                rdc(OFF_IRQ_STATUS, 32'h1);
                rdc(OFF_FILTER_DATA, m ? 32'hfff : 32'h0fff << os_f[k]);
                rdc(OFF_FILTER_CTRL, ctl(1'b1, m ? 2'b11 : 2'b00, 3'(k), 1'b1, 5'd3));
                cmp({31'h0, irq}, 32'h0);
            end
        end
        $display("test filter ratios done");
        for (int f = 1; f < 4; f++) begin
            fch = (f == 3) ? 5'd18 : 5'(18 + f);
            xfer(OFF_FILTER_CTRL + 8'(4 * f), 1'b1, ctl(1'b1, 2'b11, 3'h0, 1'b0, fch));
            repeat (2) begin
                u_adfc_conv_model.send(fch, 12'h0f0);
                @(posedge hclk);
            end
            pause(2);
            cmp({28'h0, fr}, 32'(1 << f));
            cmp({31'h0, irq}, 32'h0);
            @(posedge hclk);
            xfer(OFF_FILTER_CTRL + 8'(4 * f), 1'b1, ctl(1'b0, 2'b11, 3'h0, 1'b0, fch));
            pause(2);
            cmp({28'h0, fr}, 32'h0);
            @(posedge hclk);
            rdc(OFF_FILTER_DATA + 8'(4 * f), 32'h0f0);
            // both reserved mode codes get a turn; code 11 would be averaging
            xfer(OFF_FILTER_CTRL + 8'(4 * f), 1'b1, ctl(1'b1, (f == 2) ? 2'b01 : 2'b10, 3'h0, 1'b0, fch));
            repeat (4) begin
                u_adfc_conv_model.send(fch, 12'h0f0);
                @(posedge hclk);
            end
            pause(2);
            cmp({28'h0, fr}, 32'h0);
            @(posedge hclk);
        end
        rdc(OFF_IRQ_STATUS, 32'h0);
        $display("test inputs and modes done");
        stop_test();
    end
endmodule
`default_nettype wire
